// File: include/sensor_regs_pkg.sv
/*
  Shared constants and carrier types for the sensor device control
  register bank: register offsets, field positions, reset values,
  the fixed capabilities word and the scan timing figures.
  Assumes a 200 MHz mclk_i and the 6-bit register addressing of the
  single-wire sensor bus engine that drives the bank.
*/
package sensor_regs_pkg;

  // register offsets on the sensor bus
  localparam logic [5:0]  ADDR_IDENTITY    = 6'h02;
  localparam logic [5:0]  ADDR_CAPS        = 6'h03;
  localparam logic [5:0]  ADDR_STATUS      = 6'h04;
  localparam logic [5:0]  ADDR_CONTROL     = 6'h05;

  // identity word layout
  localparam int          REV_MSB          = 15;
  localparam int          REV_LSB          = 11;
  localparam int          PART_MSB         = 10;
  localparam int          PART_LSB         = 0;

  // capabilities: one temperature-measurement function, rest zero
  localparam logic [3:0]  FUNC_TYPE_TEMP   = 4'h1;
  localparam logic [15:0] CAPS_VALUE       = {12'h000, FUNC_TYPE_TEMP};

  // status flag positions and reset value
  localparam int          ST_EVENT_BIT     = 0;
  localparam int          ST_ERROR_BIT     = 4;
  localparam int          ST_BUS_BIT       = 7;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;

  // control field positions and reset value
  localparam int          CT_RESET_BIT     = 0;
  localparam int          CT_SHUTDOWN_BIT  = 1;
  localparam int          CT_LOW_POWER_SELECT_BIT    = 2;
  localparam int          CT_ENABLE_BIT    = 4;
  localparam logic [15:0] CONTROL_RESET    = 16'h0000;

  // timing: clock rate, scan period, device reset length
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SCAN_PERIOD_US   = 250_000;
  localparam int unsigned SCAN_CYCLES      = SCAN_PERIOD_US * CLK_MHZ;
  localparam logic [2:0]  RESET_OP_CYCLES  = 3'h4;
  localparam logic [1:0]  LOW_POWER_SELECT_LAST      = 2'h3;  // one tick in four

  // register request from the bus engine
  typedef struct packed {
    logic        write;
    logic        broadcast;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // operating mode seen by the measurement function
  typedef struct packed {
    logic shutdown;
    logic low_power;
    logic func_enable;
  } mode_t;

  // device reset sequencer states
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_RESET = 2'b01
  } op_state_t;

endpackage

// File: core/scan_pacer.sv
/*
  Scan pacer: issues one scan tick per scan period while the function
  runs, and one tick in four periods in low-power mode.
  Assumes reset_i already includes the device reset operation.
*/
module scan_pacer
  import sensor_regs_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = SCAN_CYCLES
)
(
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic run_i,
  input  wire logic slow_i,
  output logic      tick_o
);

  logic [31:0] count_r;
  logic [1:0]  slow_r;
  logic        wrap;

  // end of one active-rate period
  assign wrap = run_i && (count_r == PERIOD_CYCLES - 32'h1);

  // period counter, parked while the function is stopped
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || !run_i)
      count_r <= 32'h0;
    else if (wrap)
      count_r <= 32'h0;
    else
      count_r <= count_r + 32'h1;
  end

  // quarter-rate prescaler for low-power mode
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || !run_i)
      slow_r <= 2'h0;
    else if (wrap)
      slow_r <= slow_r + 2'h1;
  end

  // registered tick; low power drops three ticks in four
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      tick_o <= 1'b0;
    else
      tick_o <= wrap && (!slow_i || slow_r == LOW_POWER_SELECT_LAST);
  end

endmodule

// File: core/sensor_device_control_regs.sv
/*
  Device-level register bank of a multi-zone temperature sensor:
  identity, fixed capabilities, status flags and device control, with
  the device reset sequencer and the measurement scan pacer.
  Assumes a bus engine on mclk_i that decodes device numbers and the
  bit-level protocol, presenting one register request per cycle.
*/
module sensor_device_control_regs
  import sensor_regs_pkg::*;
#(
  parameter logic [4:0]  REVISION      = 5'h01,   // arbitrary value
  parameter logic [10:0] PART_CODE     = 11'h2a5, // arbitrary value
  parameter int unsigned SCAN_PERIOD   = SCAN_CYCLES
)
(
  input  wire logic      mclk_i,
  input  wire logic      reset_i,
  input  wire logic      req_valid_i,
  input  wire reg_req_t  req_i,
  input  wire logic      func_event_i,
  input  wire logic      func_error_i,
  input  wire logic      readout_read_i,
  input  wire logic      ack_error_i,
  output logic           rsp_valid_o,
  output logic [15:0]    rsp_data_o,
  output mode_t          mode_o,
  output logic           device_reset_o,
  output logic           scan_tick_o
);

  op_state_t   op_state_r;
  logic [2:0]  op_count_r;
  logic        event_flag_r;
  logic        error_flag_r;
  logic        bus_err_r;
  logic        shutdown_r;
  logic        low_power_r;
  logic        func_en_r;
  logic        resetting;
  logic        take;
  logic        rd_take;
  logic        wr_ctrl;
  logic        start_reset;
  logic        rd_status;
  logic        overrun;
  logic        run;
  logic        pacer_reset;
  logic [7:0]  status_word;
  logic [15:0] control_word;
  logic [15:0] identity_word;
  logic [15:0] read_value;

  // request qualification; accesses during a device reset are dropped
  assign resetting   = (op_state_r == ST_RESET);
  assign take        = req_valid_i && !resetting;
  // broadcast applies to writes only; this bank never looks at enable
  assign rd_take     = take && !req_i.write && !req_i.broadcast;
  assign wr_ctrl     = take && req_i.write
                       && (req_i.addr == ADDR_CONTROL);
  assign start_reset = wr_ctrl && req_i.wdata[CT_RESET_BIT];
  assign rd_status   = rd_take && (req_i.addr == ADDR_STATUS);
  assign overrun     = func_event_i && event_flag_r && !readout_read_i;

  // device reset sequencer: holds the bank in defaults for a few cycles
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      op_state_r <= ST_RUN;
      op_count_r <= 3'h0;
    end
    else
    begin
      case (op_state_r)
        ST_RUN:
        begin
          if (start_reset)
          begin
            op_state_r <= ST_RESET;
            op_count_r <= RESET_OP_CYCLES;
          end
        end
        ST_RESET:
        begin
          op_count_r <= op_count_r - 3'h1;
          if (op_count_r == 3'h1)
            op_state_r <= ST_RUN;
        end
        default:
        begin
          op_state_r <= ST_RUN;
          op_count_r <= 3'h0;
        end
      endcase
    end
  end

  assign device_reset_o = resetting;

  // event flag: a new event in the clearing cycle still sets it
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || resetting)
      event_flag_r <= STATUS_RESET[ST_EVENT_BIT];
    else if (func_event_i)
      event_flag_r <= 1'b1;
    else if (readout_read_i)
      event_flag_r <= 1'b0;
  end

  // error flag: function errors and unread-result overruns
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || resetting)
      error_flag_r <= STATUS_RESET[ST_ERROR_BIT];
    else if (func_error_i || overrun)
      error_flag_r <= 1'b1;
    else if (readout_read_i)
      error_flag_r <= 1'b0;
  end

  // bus error flag: a nack in the same cycle as a status read wins
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || resetting)
      bus_err_r <= STATUS_RESET[ST_BUS_BIT];
    else if (ack_error_i)
      bus_err_r <= 1'b1;
    else if (rd_status)
      bus_err_r <= 1'b0;
  end

  // control fields; broadcast writes touch only the shutdown bit here
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || resetting || start_reset)
    begin
      shutdown_r  <= CONTROL_RESET[CT_SHUTDOWN_BIT];
      low_power_r <= CONTROL_RESET[CT_LOW_POWER_SELECT_BIT];
      func_en_r   <= CONTROL_RESET[CT_ENABLE_BIT];
    end
    else if (wr_ctrl)
    begin
      shutdown_r <= req_i.wdata[CT_SHUTDOWN_BIT];
      if (!req_i.broadcast)
      begin
        low_power_r <= req_i.wdata[CT_LOW_POWER_SELECT_BIT];
        func_en_r   <= req_i.wdata[CT_ENABLE_BIT];
      end
    end
  end

  // register images; unused bits are tied low
  always_comb
  begin
    status_word               = STATUS_RESET;
    status_word[ST_EVENT_BIT] = event_flag_r;
    status_word[ST_ERROR_BIT] = error_flag_r;
    status_word[ST_BUS_BIT]   = bus_err_r;
  end

  always_comb
  begin
    control_word                  = CONTROL_RESET;
    control_word[CT_RESET_BIT]    = resetting;
    control_word[CT_SHUTDOWN_BIT] = shutdown_r;
    control_word[CT_LOW_POWER_SELECT_BIT]   = low_power_r;
    control_word[CT_ENABLE_BIT]   = func_en_r;
  end

  always_comb
  begin
    identity_word                   = 16'h0000;
    identity_word[REV_MSB:REV_LSB]   = REVISION;
    identity_word[PART_MSB:PART_LSB] = PART_CODE;
  end

  // read decode; addresses outside this bank answer zero
  always_comb
  begin
    if (req_i.addr == ADDR_IDENTITY)
      read_value = identity_word;
    else if (req_i.addr == ADDR_CAPS)
      read_value = CAPS_VALUE;
    else if (req_i.addr == ADDR_STATUS)
      read_value = {8'h00, status_word};
    else if (req_i.addr == ADDR_CONTROL)
      read_value = control_word;
    else
      read_value = 16'h0000;
  end

  // answer one cycle after the request; writes answer with zero data
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 16'h0000;
    end
    else
    begin
      rsp_valid_o <= rd_take || (take && req_i.write);
      rsp_data_o  <= rd_take ? read_value : 16'h0000;
    end
  end

  // mode outputs; shutdown overrides low power for the function
  assign run                = func_en_r && !shutdown_r;
  assign mode_o             = '{shutdown:    shutdown_r,
                                low_power:   low_power_r && !shutdown_r,
                                func_enable: run};
  assign pacer_reset        = reset_i || resetting;

  // conversion pacing; quartered in low-power mode
  scan_pacer #(
    .PERIOD_CYCLES (SCAN_PERIOD)
  ) u_pacer (
    .mclk_i  (mclk_i),
    .reset_i (pacer_reset),
    .run_i   (run),
    .slow_i  (low_power_r),
    .tick_o  (scan_tick_o)
  );

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // constant registers read back exactly
  property p_caps_const;
    rd_take && req_i.addr == ADDR_CAPS |=> rsp_data_o == CAPS_VALUE;
  endproperty
  a_caps_const: assert property (p_caps_const)
    else $error("capabilities read wrong");

  property p_identity;
    rd_take && req_i.addr == ADDR_IDENTITY
    |=> rsp_valid_o && rsp_data_o == {REVISION, PART_CODE};
  endproperty
  a_identity: assert property (p_identity)
    else $error("identity read wrong");

  property p_status_reserved;
    rd_take && req_i.addr == ADDR_STATUS
    |=> (rsp_data_o & 16'hff6e) == 16'h0000;
  endproperty
  a_status_reserved: assert property (p_status_reserved)
    else $error("status reserved bits not zero");

  property p_ctrl_reserved;
    rd_take && req_i.addr == ADDR_CONTROL
    |=> (rsp_data_o & 16'hffe8) == 16'h0000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("control reserved bits not zero");

  property p_bus_err_set;
    ack_error_i && !resetting |=> bus_err_r;
  endproperty
  a_bus_err_set: assert property (p_bus_err_set)
    else $error("nack did not set bus error");

  property p_bus_err_clear;
    rd_status && bus_err_r && !ack_error_i
    |=> rsp_data_o[ST_BUS_BIT] && !bus_err_r;
  endproperty
  a_bus_err_clear: assert property (p_bus_err_clear)
    else $error("status read did not clear bus error");

  property p_reset_length;
    start_reset |=> device_reset_o [*4] ##1 !device_reset_o;
  endproperty
  a_reset_length: assert property (p_reset_length)
    else $error("device reset length wrong");

  property p_reset_defaults;
    $fell(device_reset_o)
    |-> status_word == STATUS_RESET && control_word == CONTROL_RESET;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("registers not at defaults after reset");

  property p_broadcast_keep;
    wr_ctrl && req_i.broadcast && !start_reset
    |=> low_power_r == $past(low_power_r) && func_en_r == $past(func_en_r)
        && shutdown_r == $past(req_i.wdata[CT_SHUTDOWN_BIT]);
  endproperty
  a_broadcast_keep: assert property (p_broadcast_keep)
    else $error("broadcast write changed upper bits");

  property p_overrun;
    func_event_i && event_flag_r && !readout_read_i && !resetting
    |=> error_flag_r && event_flag_r;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_shutdown_quiet;
    shutdown_r |-> (!mode_o.func_enable && !mode_o.low_power)
                   ##1 !scan_tick_o;
  endproperty
  a_shutdown_quiet: assert property (p_shutdown_quiet)
    else $error("activity during shutdown");

  property p_handled_clear;
    readout_read_i && !func_event_i && !func_error_i && !resetting
    |=> !event_flag_r && !error_flag_r;
  endproperty
  a_handled_clear: assert property (p_handled_clear)
    else $error("readout read did not clear flags");

  // main scenarios
  c_broadcast_reset: cover property (wr_ctrl && req_i.broadcast
                                     && start_reset);
  c_overrun: cover property (overrun);
  c_nack_then_read: cover property (ack_error_i ##[1:8] rd_status);
  c_low_power_tick: cover property (low_power_r && scan_tick_o);

endmodule

// File: test/bus_master_model.sv
/*
  Behavioural model of the sensor bus engine on the far side of the
  register bank: issues one register request at a time and takes the
  registered answer 1 ns after the taking edge.
  Assumes the bank answers every accepted write and own read in the next cycle.
*/
module bus_master_model
  import sensor_regs_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [15:0] rsp_data_i,
  output logic             req_valid_o,
  output reg_req_t         req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle at start; no device reset command is needed after power-up
  initial
  begin
    req_valid_o = 1'b0;
    req_o       = '0;
  end

  // one request pulse, then sample the answer once the edge has landed
  task automatic xfer(input  reg_req_t    r,
                      output logic        got,
                      output logic [15:0] d);
    @(posedge mclk_i);
    req_valid_o <= 1'b1;
    req_o       <= r;
    @(posedge mclk_i);
    req_valid_o <= 1'b0;
    req_o       <= ~r;  // released lines must not keep a stale copy
    #1;
    got = rsp_valid_i;
    d   = rsp_data_i;
  endtask
endmodule

// File: test/tb.sv
/*
  Self-checking bench for the sensor device control register bank:
  reset values, control masking, broadcast writes, status flags,
  device reset operation and scan pacing.
  Assumes a shortened scan period so pacing shows in a few cycles.
*/
module tb
  import sensor_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned PER = 8;
  localparam logic [4:0]  REV = 5'h0b;   // arbitrary value
  localparam logic [10:0] PC  = 11'h155; // arbitrary value

  logic        mclk      = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  ev        = 4'h0;  // {ack_err, readout, error, event}
  logic        req_valid;
  reg_req_t    req;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  mode_t       mode;
  logic        dev_rst;
  logic        tick;
  int          n_fail    = 0;
  int          compares  = 0;
  int          seed      = 32'hc92a;

  sensor_device_control_regs #(.REVISION(REV), .PART_CODE(PC),
                               .SCAN_PERIOD(PER)) i_dut (
    .mclk_i(mclk), .reset_i(rst), .req_valid_i(req_valid),
    .req_i(req), .func_event_i(ev[0]), .func_error_i(ev[1]),
    .readout_read_i(ev[2]), .ack_error_i(ev[3]),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .mode_o(mode),
    .device_reset_o(dev_rst), .scan_tick_o(tick));

  bus_master_model i_master (
    .mclk_i(mclk), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
    .req_valid_o(req_valid), .req_o(req));

  // 200 mhz clock
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  // expected control word; broadcast only moves the shutdown bit
  function automatic logic [15:0] exp_ctrl(logic [15:0] old, w, logic bc);
    return bc ? {old[15:2], w[1], 1'b0} : (w & 16'h0016);
  endfunction

  // shutdown masks both low power and enable towards the function
  function automatic logic [15:0] exp_mode(logic [15:0] c);
    return {13'h0000, c[1], c[2] & ~c[1], c[4] & ~c[1]};
  endfunction

  task automatic chk(input logic [15:0] got, exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] w,
                    input logic bc);
    logic        g;
    logic [15:0] d;
    i_master.xfer('{1'b1, bc, a, w}, g, d);
    chk({15'h0000, g}, 16'h0001, "write answer");
  endtask

  task automatic rdc(input logic [5:0] a, input logic [15:0] e,
                     input string m);
    logic        g;
    logic [15:0] d;
    i_master.xfer('{1'b0, 1'b0, a, 16'h0000}, g, d);
    chk({15'h0000, g}, 16'h0001, "read answer");
    chk(d, e, m);
  endtask

  // one-cycle pulse on the function and bus event inputs
  task automatic pulse(input logic [3:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 4'h0;
    #1;
  endtask

  // cycles between two scan ticks, bounded both ways
  task automatic gap(output int g);
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 400)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    g = 0;
    do
    begin
      @(posedge mclk);
      #1;
      g++;
    end while (tick !== 1'b1 && g < 400);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #50000;
    n_fail++;
    results();
  end

  initial
  begin
    logic [15:0] c;
    logic [15:0] w;
    logic [15:0] d;
    logic        g;
    int          n;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    // power-up values
    rdc(ADDR_IDENTITY, {REV, PC}, "identity");
    rdc(ADDR_CAPS, 16'h0001, "capabilities");
    rdc(ADDR_STATUS, 16'h0000, "status reset");
    rdc(ADDR_CONTROL, 16'h0000, "control reset");
    chk(16'(mode), 16'h0000, "mode reset");
    rdc(6'h3f, 16'h0000, "unmapped read");
    wr(ADDR_CAPS, 16'hffff, 1'b0);
    rdc(ADDR_CAPS, 16'h0001, "capabilities kept");
    // broadcast reads get no answer
    i_master.xfer('{1'b0, 1'b1, ADDR_CONTROL, 16'h0000}, g, d);
    chk({15'h0000, g}, 16'h0000, "broadcast read");
    // random own and broadcast control writes, bit 0 kept clear
    c = 16'h0000;
    for (int i = 0; i < 10; i++)
    begin
      w = 16'($random(seed));
      w[0] = 1'b0;
      if (i == 0)
        w = 16'hfffe;
      wr(ADDR_CONTROL, w, 1'(i % 2));
      c = exp_ctrl(c, w, 1'(i % 2));
      chk(16'(mode), exp_mode(c), "mode");
      rdc(ADDR_CONTROL, c, "control");
    end
    // status flags: event, overrun, bus error, clear on read
    wr(ADDR_CONTROL, 16'h0000, 1'b0);
    pulse(4'h1);
    rdc(ADDR_STATUS, 16'h0001, "event flag");
    pulse(4'h1);
    rdc(ADDR_STATUS, 16'h0011, "overrun");
    pulse(4'h8);
    rdc(ADDR_STATUS, 16'h0091, "bus error");
    rdc(ADDR_STATUS, 16'h0011, "bus error read");
    wr(ADDR_STATUS, 16'hffff, 1'b0);
    pulse(4'h2);
    rdc(ADDR_STATUS, 16'h0011, "status kept");
    pulse(4'h4);
    rdc(ADDR_STATUS, 16'h0000, "handled");
    // device reset from the control register
    wr(ADDR_CONTROL, 16'h0016, 1'b0);
    pulse(4'h9);
    wr(ADDR_CONTROL, 16'h0017, 1'b0);
    n = 0;
    while (dev_rst === 1'b1 && n < 20)
    begin
      n++;
      @(posedge mclk);
      #1;
    end
    chk(16'(n), 16'(RESET_OP_CYCLES), "reset length");
    rdc(ADDR_CONTROL, 16'h0000, "control after");
    rdc(ADDR_STATUS, 16'h0000, "status after");
    chk(16'(mode), 16'h0000, "mode after");
    // a broadcast reset, then a request during it is dropped
    wr(ADDR_CONTROL, 16'h0001, 1'b1);
    i_master.xfer('{1'b0, 1'b0, ADDR_STATUS, 16'h0000}, g, d);
    chk({15'h0000, g}, 16'h0000, "request in reset");
    repeat (6) @(posedge mclk);
    // scan pacing: active, low power, shutdown
    wr(ADDR_CONTROL, 16'h0010, 1'b0);
    gap(n);
    chk(16'(n), 16'(PER), "active scan");
    wr(ADDR_CONTROL, 16'h0014, 1'b0);
    gap(n);
    gap(n);
    chk(16'(n), 16'(4 * PER), "slow scan");
    wr(ADDR_CONTROL, 16'h0016, 1'b0);
    n = 0;
    repeat (5 * PER)
    begin
      @(posedge mclk);
      #1;
      if (tick === 1'b1)
        n++;
    end
    chk(16'(n), 16'h0000, "shutdown scan");
    results();
  end
endmodule
